// ### hdl/sync_rx_defs.svh
`ifndef SYNC_RX_DEFS_SVH
`define SYNC_RX_DEFS_SVH

// register address width and byte offsets
`define ADDR_W 8
`define OFS_RX_DATA 8'h00
`define OFS_RX_STAT 8'h04
`define OFS_TX_STAT 8'h08
`define OFS_BAUD 8'h0C
`define OFS_DIV_LO 8'h10
`define OFS_DIV_HI 8'h14
`define OFS_IRQ_CTL 8'h18

// receive_status_control fields
`define RSC_PORT_EN 7
`define RSC_NINE 6
`define RSC_SINGLE_RECEIVE_ENABLE 5
`define RSC_CONTINUOUS_RECEIVE_ENABLE 4
`define RSC_OVERRUN_ERROR_FLAG 1
`define RSC_NINTH 0

// transmit_status_control fields
`define TSC_MASTER 7
`define TSC_SYNC 4
`define TSC_HIGH_RATE 2

// baud_control fields
`define BDC_IDLE 6
`define BDC_POL 4
`define BDC_DIV16 3

// interrupt control fields
`define IRC_IE 0
`define IRC_FLAG 1

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// character, fifo and half-period counter sizes
`define CHAR_W 9
`define CHAR_BITS_8 4'h8
`define CHAR_BITS_9 4'h9
`define FIFO_FULL 2'h2
`define HALF_W 18

`endif

// ### hdl/sync_rx_pkg.sv
`include "sync_rx_defs.svh"

package sync_rx_pkg;

  // master shift clock phases, gray along idle -> active -> trail
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_ACTIVE = 2'h1,
    PH_TRAIL = 2'h3
  } phase_e;

  typedef struct packed {
    // bus slave
    logic awready;
    logic wready;
    logic aw_held;
    logic [`ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_en;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // control
    logic port_enable;
    logic nine_bit_receive_enable;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic clock_source_master;
    logic sync_mode;
    logic high_rate_select;
    logic clock_polarity_select;
    logic sixteen_bit_divisor_select;
    logic [7:0] divisor_low_byte;
    logic [7:0] divisor_high_byte;
    logic receive_interrupt_enable;
    // status
    logic overrun_error_flag;
    logic overrun_in_single;
    // receiver
    phase_e phase;
    logic [`HALF_W-1:0] half_cnt;
    logic [3:0] bit_cnt;
    logic [`CHAR_W-1:0] receive_shift_register;
    // pin synchronisers
    logic data_s1;
    logic data_s2;
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    // pins
    logic clk_out;
    logic clk_oe;
    logic data_out;
    logic data_oe;
    logic irq;
  } state_s;

  typedef struct packed {
    logic [1:0] mem_rd_ptr_count_pad;
  } unused_s;

endpackage

// ### hdl/rx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_defs.svh"

module rx_fifo (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic flush,
  input wire logic push,
  input wire logic [`CHAR_W-1:0] din,
  input wire logic pop,
  // state
  output logic [`CHAR_W-1:0] head,
  output logic [1:0] count
);

  typedef struct packed {
    logic [1:0][`CHAR_W-1:0] mem;
    logic rd_ptr;
    logic [1:0] count;
  } fifo_s;

  fifo_s s;
  fifo_s n;
  logic do_pop;
  logic do_push;

  always_comb begin
    n = s;
    do_pop = pop && (s.count != 2'h0);
    // a full fifo still takes a push when the same cycle frees the head
    do_push = push && ((s.count != `FIFO_FULL) || do_pop);
    if (flush) begin
      n = '0;
    end else begin
      if (do_push) begin
        n.mem[s.rd_ptr ^ s.count[0]] = din;
      end
      if (do_pop) begin
        n.rd_ptr = ~s.rd_ptr;
      end
      n.count = s.count + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign head = s.mem[s.rd_ptr];
  assign count = s.count;

endmodule

`default_nettype wire

// ### hdl/sync_serial_receiver.sv
// Behaviour
// R1: master receive keeps the data pin driver off; pin is input only.
// R2: synchronous reception starts when single or continuous receive is set.
// R3: single receive alone gives one character of clocks, then clears itself.
// R4: continuous receive clocks until cleared; clearing mid-character aborts it.
// R5: both set: single clears after first character, continuous carries on.
// R6: data pin sampled on trailing clock edge into the shift register.
// R7: full character sets receive flag, enters two-entry fifo; low byte readable.
// R8: receive flag stays set while the fifo holds any unread character.
// R9: slave configuration takes clock from pin with its driver off.
// R10: data changes on leading edge, stable at trailing; one bit per clock.
// R11: an external master gives only as many clocks as character bits.
// R12: third character into full fifo sets overrun, kept data, reception halts.
// R13: overrun from single receive is cleared by reading receive data.
// R14: overrun from continuous receive clears with continuous or port enable clear.
// R15: nine-bit mode shifts nine bits; status shows ninth bit of oldest.
// R16: software reads ninth bit before low byte, since that read pops.
// R17: master mode needs synchronous select, port enable and clock master set.
// R18: software clears both receive enables before enabling master reception.
// R19: interrupt request when receive flag and receive interrupt enable set.
// R20: shift clock is system clock over four times divisor plus one.
// R21: sync select clear means asynchronous; port enable drives clock pin out.
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_defs.svh"

module sync_serial_receiver (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial data pin
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // serial clock pin
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // interrupt request
  output logic receive_irq
);

  sync_rx_pkg::state_s s;
  sync_rx_pkg::state_s n;

  logic [`CHAR_W-1:0] fifo_head;
  logic [1:0] fifo_count;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_flush;
  logic [`CHAR_W-1:0] fifo_din;
  logic master_run;
  logic slave_run;
  logic got_bit;
  logic [3:0] char_bits;
  logic receive_flag;

  // lsb first: new bits enter at the top and walk down
  function automatic logic [`CHAR_W-1:0] shift_bit(input logic [`CHAR_W-1:0] sh,
                                                   input logic b);
    return {b, sh[`CHAR_W-1:1]};
  endfunction

  // an eight-bit character sits one place high in the shift register
  function automatic logic [`CHAR_W-1:0] char_of(input logic [`CHAR_W-1:0] sh,
                                                 input logic nine);
    return nine ? sh : {1'b0, sh[`CHAR_W-1:1]};
  endfunction

  // half a shift clock lasts 2*(div+1) cycles; this is that count minus one
  function automatic logic [`HALF_W-1:0] half_reload(input logic [7:0] lo,
                                                     input logic [7:0] hi,
                                                     input logic wide);
    logic [15:0] div;
    div = wide ? {hi, lo} : {8'h00, lo};
    return {1'b0, div, 1'b1};
  endfunction

  function automatic logic [33:0] read_word(input sync_rx_pkg::state_s st,
                                            input logic [`ADDR_W-1:0] addr,
                                            input logic [`CHAR_W-1:0] head,
                                            input logic flag);
    logic [7:0] b;
    logic [1:0] resp;
    b = 8'h00;
    resp = `RESP_OKAY;
    case (addr)
      `OFS_RX_DATA: begin
        b = head[7:0]; // R7
      end
      `OFS_RX_STAT: begin
        b[`RSC_PORT_EN] = st.port_enable;
        b[`RSC_NINE] = st.nine_bit_receive_enable;
        b[`RSC_SINGLE_RECEIVE_ENABLE] = st.single_receive_enable;
        b[`RSC_CONTINUOUS_RECEIVE_ENABLE] = st.continuous_receive_enable;
        b[`RSC_OVERRUN_ERROR_FLAG] = st.overrun_error_flag;
        b[`RSC_NINTH] = head[`CHAR_W-1]; // R15
      end
      `OFS_TX_STAT: begin
        b[`TSC_MASTER] = st.clock_source_master;
        b[`TSC_SYNC] = st.sync_mode;
        b[`TSC_HIGH_RATE] = st.high_rate_select;
      end
      `OFS_BAUD: begin
        b[`BDC_IDLE] = (st.phase == sync_rx_pkg::PH_IDLE) && (st.bit_cnt == 4'h0);
        b[`BDC_POL] = st.clock_polarity_select;
        b[`BDC_DIV16] = st.sixteen_bit_divisor_select;
      end
      `OFS_DIV_LO: begin
        b = st.divisor_low_byte;
      end
      `OFS_DIV_HI: begin
        b = st.divisor_high_byte;
      end
      `OFS_IRQ_CTL: begin
        b[`IRC_IE] = st.receive_interrupt_enable;
        b[`IRC_FLAG] = flag;
      end
      default: begin
        resp = `RESP_SLVERR;
      end
    endcase
    return {resp, 24'h000000, b};
  endfunction

  rx_fifo rx_fifo_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(fifo_flush),
    .push(fifo_push),
    .din(fifo_din),
    .pop(fifo_pop),
    .head(fifo_head),
    .count(fifo_count)
  );

  assign receive_flag = (fifo_count != 2'h0); // R8

  always_comb begin
    n = s;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    fifo_din = '0;
    got_bit = 1'b0;
    // clearing the port enable resets the whole receive path
    fifo_flush = !s.port_enable; // R14
    char_bits = s.nine_bit_receive_enable ? `CHAR_BITS_9 : `CHAR_BITS_8; // R15
    master_run = s.port_enable && s.sync_mode && s.clock_source_master // R17
                 && (s.single_receive_enable || s.continuous_receive_enable) // R2
                 && !s.overrun_error_flag; // R12
    slave_run = s.port_enable && s.sync_mode && !s.clock_source_master
                && (s.single_receive_enable || s.continuous_receive_enable) // R2
                && !s.overrun_error_flag; // R12

    // two flops on the data pin, three on the clock pin; edges only looked at past the second
    n.data_s1 = serial_data_pin_in;
    n.data_s2 = s.data_s1;
    n.clk_s1 = serial_clock_pin_in;
    n.clk_s2 = s.clk_s1;
    n.clk_s3 = s.clk_s2;

    // write channels, taken in either order
    if (awvalid && s.awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_held = 1'b1;
      n.w_data = wdata[7:0];
      n.w_en = wstrb[0];
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (s.aw_addr)
        `OFS_RX_DATA: begin
        end
        `OFS_RX_STAT: begin
          if (s.w_en) begin
            n.port_enable = s.w_data[`RSC_PORT_EN];
            n.nine_bit_receive_enable = s.w_data[`RSC_NINE];
            n.single_receive_enable = s.w_data[`RSC_SINGLE_RECEIVE_ENABLE];
            n.continuous_receive_enable = s.w_data[`RSC_CONTINUOUS_RECEIVE_ENABLE];
          end
        end
        `OFS_TX_STAT: begin
          if (s.w_en) begin
            n.clock_source_master = s.w_data[`TSC_MASTER];
            n.sync_mode = s.w_data[`TSC_SYNC];
            n.high_rate_select = s.w_data[`TSC_HIGH_RATE];
          end
        end
        `OFS_BAUD: begin
          if (s.w_en) begin
            n.clock_polarity_select = s.w_data[`BDC_POL];
            n.sixteen_bit_divisor_select = s.w_data[`BDC_DIV16];
          end
        end
        `OFS_DIV_LO: begin
          if (s.w_en) begin
            n.divisor_low_byte = s.w_data;
          end
        end
        `OFS_DIV_HI: begin
          if (s.w_en) begin
            n.divisor_high_byte = s.w_data;
          end
        end
        `OFS_IRQ_CTL: begin
          if (s.w_en) begin
            n.receive_interrupt_enable = s.w_data[`IRC_IE];
          end
        end
        default: begin
          n.bresp = `RESP_SLVERR;
        end
      endcase
    end
    n.awready = !n.aw_held;
    n.wready = !n.w_held;

    // read channel; a read of receive data pops the oldest character
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      {n.rresp, n.rdata} = read_word(s, araddr, fifo_head, receive_flag);
      if (araddr == `OFS_RX_DATA) begin
        fifo_pop = 1'b1; // R16
        if (s.overrun_error_flag && s.overrun_in_single) begin
          n.overrun_error_flag = 1'b0; // R13
        end
      end
    end
    n.arready = !n.rvalid;

    if (s.overrun_error_flag && !s.overrun_in_single && !s.continuous_receive_enable) begin
      n.overrun_error_flag = 1'b0; // R14
    end

    // master shift clock; leading edge leaves the idle level
    case (s.phase)
      sync_rx_pkg::PH_IDLE: begin
        n.clk_out = s.clock_polarity_select;
        if (master_run) begin
          n.phase = sync_rx_pkg::PH_ACTIVE;
          n.clk_out = !s.clock_polarity_select; // R10
          n.half_cnt = half_reload(s.divisor_low_byte, s.divisor_high_byte,
                                   s.sixteen_bit_divisor_select); // R20
        end
      end
      sync_rx_pkg::PH_ACTIVE: begin
        if (!master_run) begin
          n.phase = sync_rx_pkg::PH_IDLE; // R4
          n.clk_out = s.clock_polarity_select;
          n.bit_cnt = 4'h0;
        end else if (s.half_cnt == '0) begin
          n.phase = sync_rx_pkg::PH_TRAIL;
          n.clk_out = s.clock_polarity_select;
          n.half_cnt = half_reload(s.divisor_low_byte, s.divisor_high_byte,
                                   s.sixteen_bit_divisor_select); // R20
          got_bit = 1'b1; // R6
        end else begin
          n.half_cnt = s.half_cnt - `HALF_W'(1);
        end
      end
      sync_rx_pkg::PH_TRAIL: begin
        if (!master_run) begin
          n.phase = sync_rx_pkg::PH_IDLE; // R3
          n.clk_out = s.clock_polarity_select;
          n.bit_cnt = 4'h0;
        end else if (s.half_cnt == '0) begin
          n.phase = sync_rx_pkg::PH_ACTIVE;
          n.clk_out = !s.clock_polarity_select; // R10
          n.half_cnt = half_reload(s.divisor_low_byte, s.divisor_high_byte,
                                   s.sixteen_bit_divisor_select); // R20
        end else begin
          n.half_cnt = s.half_cnt - `HALF_W'(1);
        end
      end
      default: begin
        n.phase = sync_rx_pkg::PH_IDLE;
        n.clk_out = s.clock_polarity_select;
      end
    endcase

    // slave: trailing edge is the return to the idle level
    if (slave_run) begin
      if ((s.clk_s3 != s.clock_polarity_select) && (s.clk_s2 == s.clock_polarity_select)) begin
        got_bit = 1'b1; // R9
      end
    end else if (!master_run) begin
      n.bit_cnt = 4'h0;
    end

    // one bit per clock; the count closes a character
    if (got_bit) begin
      n.receive_shift_register = shift_bit(s.receive_shift_register, s.data_s2); // R6
      n.bit_cnt = s.bit_cnt + 4'h1;
      if (n.bit_cnt == char_bits) begin
        n.bit_cnt = 4'h0;
        n.single_receive_enable = 1'b0; // R3 R5
        if ((fifo_count == `FIFO_FULL) && !fifo_pop) begin
          // the stored pair is kept; the new character is dropped
          n.overrun_error_flag = 1'b1; // R12
          n.overrun_in_single = s.single_receive_enable && !s.continuous_receive_enable;
        end else begin
          fifo_push = 1'b1; // R7
          fifo_din = char_of(n.receive_shift_register, s.nine_bit_receive_enable);
        end
      end
    end

    if (!s.port_enable) begin
      n.phase = sync_rx_pkg::PH_IDLE; // R14
      n.half_cnt = '0;
      n.bit_cnt = 4'h0;
      n.receive_shift_register = '0;
      n.overrun_error_flag = 1'b0;
      n.overrun_in_single = 1'b0;
    end

    // pins: data is never driven by a receiver
    n.data_out = 1'b0;
    n.data_oe = 1'b0; // R1
    n.clk_oe = s.port_enable && (!s.sync_mode || s.clock_source_master); // R21
    // irq lags the fifo count by one cycle so that it leaves a flop
    n.irq = receive_flag && s.receive_interrupt_enable; // R19
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bresp = s.bresp;
  assign bvalid = s.bvalid;
  assign arready = s.arready;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rvalid = s.rvalid;
  assign serial_data_pin_out = s.data_out;
  assign serial_data_pin_oe = s.data_oe;
  assign serial_clock_pin_out = s.clk_out;
  assign serial_clock_pin_oe = s.clk_oe;
  assign receive_irq = s.irq;

endmodule

`default_nettype wire

// ### verification/sync_rx_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_defs.svh"
module sync_rx_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // serial pins
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [`ADDR_W-1:0] ar_reg;
  always_ff @(posedge aclk) begin
    if (arvalid && arready) ar_reg <= araddr;
  end
  chk_data_undriven: assert property (!serial_data_pin_oe && !serial_data_pin_out)
    else $error("data pin driven");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  chk_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  chk_read_high_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_mapped_okay: assert property (rvalid && ar_reg <= `OFS_IRQ_CTL && ar_reg[1:0] == 2'h0
    |-> rresp == `RESP_OKAY)
    else $error("mapped read refused");
  // every half period spans at least two cycles, even at divisor zero
  chk_clock_half: assert property ($changed(serial_clock_pin_out) |=> $stable(serial_clock_pin_out))
    else $error("clock half period short");
  chk_pin_dir_write: assert property ($changed(serial_clock_pin_oe) |-> bvalid || $past(bvalid))
    else $error("clock pin direction moved alone");
endmodule
`default_nettype wire

// ### verification/sync_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module sync_peer_model (
  // shift clock as seen on the pin
  input wire logic ck,
  // driven lines
  output logic data,
  output logic clk
);
  logic [8:0] q[$];
  logic [8:0] cur;
  logic own;
  int n;
  int nb;
  initial begin
    data = 1'b1;
    clk = 1'b0;
    own = 1'b0;
    cur = 9'h000;
    n = 0;
    nb = 8;
  end
  // next bit goes out on the leading edge, lsb first
  always @(posedge ck) begin
    if (!own) begin
      if (n == 0) cur = (q.size() > 0) ? q.pop_front() : 9'h000;
      data <= cur[n];
      n = (n + 1 == nb) ? 0 : n + 1;
    end
  end
  // line let go after a character must not keep showing the last bit
  always @(negedge ck) begin
    if (!own && n == 0) #100 data <= ~data;
  end
  // peer as clock master: k clocks, then the clock stands still
  task automatic send(input logic [8:0] c, input int k);
    own = 1'b1;
    #7;
    for (int i = 0; i < k; i++) begin
      clk = 1'b1;
      data = c[i];
      #80 clk = 1'b0;
      #80;
    end
    data = ~data;
    own = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/sync_serial_receiver_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_defs.svh"
module sync_serial_receiver_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, dt_out, dt_oe, ck_out, ck_oe, irq;
  logic peer_dt, peer_ck;
  logic [`ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int err_count, checks_done, lead_cnt, base, per;
  time last;
  wire logic ck_w = ck_oe ? ck_out : peer_ck;
  wire logic dt_w = dt_oe ? dt_out : peer_dt;
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge ck_w) begin
    per = int'($time - last);
    last = $time;
    lead_cnt++;
  end
  sync_serial_receiver sync_serial_receiver_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_data_pin_in(dt_w), .serial_data_pin_out(dt_out), .serial_data_pin_oe(dt_oe),
    .serial_clock_pin_in(ck_w), .serial_clock_pin_out(ck_out), .serial_clock_pin_oe(ck_oe),
    .receive_irq(irq)
  );
  sync_peer_model sync_peer_model_inst (.ck(ck_w), .data(peer_dt), .clk(peer_ck));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && t < 99);
    if (!bvalid) begin
      err_count++;
      $display("Error at %0t: write answer timed out", $time);
    end
    // late bready makes the answer stand one cycle unacknowledged
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && t < 99);
    if (!rvalid) begin
      err_count++;
      $display("Error at %0t: read answer timed out", $time);
    end
    rready <= 1'b1;
    @(posedge aclk);
    v = rdata;
    e = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] x;
    rd(a, v, x);
    chk(v, e);
  endtask
  // waits for n leading edges, then lets the character land
  task automatic wait_lead(input int n, input int extra);
    int t;
    t = 0;
    while (lead_cnt < n && t < 9999) begin
      @(posedge aclk);
      t++;
    end
    if (lead_cnt < n) begin
      err_count++;
      $display("Error at %0t: shift clock edges missing", $time);
    end
    repeat (extra) @(posedge aclk);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    err_count = 0;
    checks_done = 0;
    lead_cnt = 0;
    last = 0;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // after reset only the receiver idle bit of baud_control reads set
    for (int i = 0; i < 7; i++) rchk(8'(4 * i), (i == 3) ? 32'h40 : 32'h0);
    rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    chk(d, 32'h0);
    wr(8'h40, 8'h00, `RESP_SLVERR);
    wr(`OFS_DIV_LO, 8'h03, `RESP_OKAY);
    wr(`OFS_TX_STAT, 8'h90, `RESP_OKAY);
    wr(`OFS_IRQ_CTL, 8'h01, `RESP_OKAY);
    wr(`OFS_RX_STAT, 8'h80, `RESP_OKAY);
    rchk(`OFS_TX_STAT, 32'h90);
    chk({31'h0, ck_oe}, 32'h1);
    sync_peer_model_inst.q.push_back(9'h04D);
    base = lead_cnt;
    wr(`OFS_RX_STAT, 8'hA0, `RESP_OKAY);
    wait_lead(base + 8, 60);
    chk(32'(lead_cnt - base), 32'h8);
    chk(32'(per), 32'h140);
    chk({31'h0, irq}, 32'h1);
    rchk(`OFS_RX_STAT, 32'h80);
    rchk(`OFS_IRQ_CTL, 32'h03);
    rchk(`OFS_RX_DATA, 32'h4D);
    rchk(`OFS_IRQ_CTL, 32'h01);
    for (int i = 1; i < 4; i++) begin
      sync_peer_model_inst.q.push_back(9'(8'h30 + 8'(i)));
      base = lead_cnt;
      wr(`OFS_RX_STAT, 8'hA0, `RESP_OKAY);
      wait_lead(base + 8, 30);
    end
    rchk(`OFS_RX_STAT, 32'h82);
    rchk(`OFS_RX_DATA, 32'h31);
    rchk(`OFS_RX_STAT, 32'h80);
    rchk(`OFS_RX_DATA, 32'h32);
    rchk(`OFS_IRQ_CTL, 32'h01);
    sync_peer_model_inst.q = '{9'h01E, 9'h02C, 9'h047};
    base = lead_cnt;
    wr(`OFS_RX_STAT, 8'hB0, `RESP_OKAY);
    wait_lead(base + 8, 30);
    rchk(`OFS_RX_STAT, 32'h90);
    wait_lead(base + 24, 200);
    chk(32'(lead_cnt - base), 32'h18);
    rchk(`OFS_RX_DATA, 32'h1E);
    rchk(`OFS_RX_STAT, 32'h92);
    wr(`OFS_RX_STAT, 8'h80, `RESP_OKAY);
    rchk(`OFS_RX_STAT, 32'h80);
    rchk(`OFS_RX_DATA, 32'h2C);
    sync_peer_model_inst.q.push_back(9'h0FF);
    base = lead_cnt;
    wr(`OFS_RX_STAT, 8'h90, `RESP_OKAY);
    wait_lead(base + 4, 0);
    wr(`OFS_RX_STAT, 8'h80, `RESP_OKAY);
    wait_lead(0, 200);
    chk(32'(lead_cnt - base), 32'h4);
    chk({31'h0, ck_out}, 32'h0);
    rchk(`OFS_IRQ_CTL, 32'h01);
    sync_peer_model_inst.n = 0;
    sync_peer_model_inst.nb = 9;
    sync_peer_model_inst.q.push_back(9'h13C);
    base = lead_cnt;
    wr(`OFS_RX_STAT, 8'hE0, `RESP_OKAY);
    wait_lead(base + 9, 60);
    rchk(`OFS_RX_STAT, 32'hC1);
    rchk(`OFS_RX_DATA, 32'h3C);
    wr(`OFS_TX_STAT, 8'h10, `RESP_OKAY);
    wr(`OFS_RX_STAT, 8'h90, `RESP_OKAY);
    chk({31'h0, ck_oe}, 32'h0);
    sync_peer_model_inst.send(9'h0B2, 8);
    repeat (20) @(posedge aclk);
    rchk(`OFS_RX_DATA, 32'hB2);
    wr(`OFS_BAUD, 8'h18, `RESP_OKAY);
    rchk(`OFS_BAUD, 32'h58);
    chk({31'h0, ck_out}, 32'h1);
    summarize();
  end
endmodule
bind sync_serial_receiver sync_rx_sva sync_rx_sva_inst (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe(serial_clock_pin_oe)
);
`default_nettype wire
